//--- src/svd_pkg.sv
// shared constants and types for the soft viterbi decoder with error monitor
package svd_pkg;
	localparam int SOFT_W = 5;
	localparam int NUM_ST = 64;
	localparam int TB_LEN = 128;
	localparam int BLK_LEN = 64;
	localparam int MEM_DEPTH = 256;
	localparam int PM_W = 10;
	localparam int ERR_W = 24;
	localparam int CNT_W = 7;
	// survivor words between newest step and first step of the block being decoded
	localparam logic [7:0] DEC_LAG = 8'h00_C0;
	localparam logic [6:0] TB_LAST = 7'h00_7F;
	localparam logic [6:0] BLK_LAST = 7'h00_3F;
	// mother code taps, bit 6 is the current input bit
	localparam logic [6:0] GEN_X = 7'h00_79;
	localparam logic [6:0] GEN_Y = 7'h00_5B;
	localparam logic [4:0] SOFT_MAX = 5'h1F;
	localparam logic [1:0] WARM_BLKS = 2'h2;
	typedef enum logic [2:0]
	{
		RATE_1_2 = 3'h0,
		RATE_2_3 = 3'h1,
		RATE_3_4 = 3'h2,
		RATE_5_6 = 3'h3,
		RATE_7_8 = 3'h4
	} svd_rate_type;
	typedef enum logic [3:0]
	{
		ST_FILL = 4'h1,
		ST_TRACE = 4'h2,
		ST_DECODE = 4'h4,
		ST_EMIT = 4'h8
	} svd_state_type;
	// puncture masks per rate, bit p set when that code bit is sent at step p
	localparam logic [6:0] PUNCT_X [5] = '{7'h01, 7'h01, 7'h05, 7'h15, 7'h51};
	localparam logic [6:0] PUNCT_Y [5] = '{7'h01, 7'h03, 7'h03, 7'h0B, 7'h2F};
	localparam logic [2:0] PUNCT_PER [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
endpackage

//--- src/svd_ber_mon.sv
// re-encoding input bit error monitor with programmable interval
`timescale 1ns/1ps
module svd_ber_mon
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic bit_i,
	input wire logic valid_i,
	input wire logic hard_x_i,
	input wire logic hard_y_i,
	input wire logic era_x_i,
	input wire logic era_y_i,
	input wire logic [svd_pkg::ERR_W-1:0] period_i,
	output logic [svd_pkg::ERR_W-1:0] count_o,
	output logic done_o
);
	logic [5:0] enc_ff;
	logic [svd_pkg::ERR_W-1:0] acc_ff;
	logic [svd_pkg::ERR_W-1:0] len_ff;
	logic [1:0] err;
	logic re_x;
	logic re_y;
	logic last;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	// re-encode the decoded bit, compare against the delayed hard decisions
	assign re_x = ^({bit_i, enc_ff} & svd_pkg::GEN_X);
	assign re_y = ^({bit_i, enc_ff} & svd_pkg::GEN_Y);
	// R5 mismatch count
	assign err = {1'b0, !era_x_i && (re_x != hard_x_i)} + {1'b0, !era_y_i && (re_y != hard_y_i)};
	// a zero interval behaves as one bit
	assign last = (len_ff + 1'b1) >= period_i;

	// encoder state follows the decoded stream
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			enc_ff <= '0;
		else if (valid_i)
			enc_ff <= {bit_i, enc_ff[5:1]};
	end

	// R6 interval accumulate
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			acc_ff <= '0;
			len_ff <= '0;
			count_o <= '0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= valid_i && last;
			if (valid_i && last)
			begin
				count_o <= acc_ff + svd_pkg::ERR_W'(err);
				acc_ff <= '0;
				len_ff <= '0;
			end
			else if (valid_i)
			begin
				acc_ff <= acc_ff + svd_pkg::ERR_W'(err);
				len_ff <= len_ff + 1'b1;
			end
		end
	end

	property p_err_count;
		valid_i && !last |=> acc_ff == $past(acc_ff) + svd_pkg::ERR_W'($past(err));
	endproperty
	a_err_count: assert property (p_err_count) else $error("error count not accumulated"); // R5

	property p_interval_end;
		valid_i && last |=> done_o && count_o == $past(acc_ff) + svd_pkg::ERR_W'($past(err))
			&& acc_ff == '0;
	endproperty
	a_interval_end: assert property (p_interval_end) else $error("interval result wrong"); // R6
endmodule

//--- src/svd_decoder.sv
// soft viterbi decoder: depuncture, 64-state acs, block trace-back, error monitor
// Behaviour
// R1 - each code bit arrives as a 5-bit soft value and all five bits enter the branch metric.
// R2 - for every rate but 1/2 the punctured positions are refilled as erasures costing nothing.
// R3 - a 64-state add-compare-select writes one 64-bit decision word per trellis step.
// R4 - decoded bits come from tracing the stored decisions back over 128 steps.
// R5 - decoded bits are re-encoded and mismatches with the delayed hard decisions are counted.
// R6 - the error count covers a programmable interval and is published at its end.
// R7 - the consumer passes the decoded stream through a depth-12 convolutional de-interleaver.
// R8 - only the selected priority stream is decoded, and a new selection applies cleanly.
// R9 - the consumer aligns the decoded stream into 204-byte frames with robust sync.
// R10 - the trellis is the rate 1/2 mother code, punctured by the usual patterns.
`timescale 1ns/1ps
module svd_decoder
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [2:0] code_rate_i,
	input wire logic prio_sel_i,
	input wire logic [svd_pkg::SOFT_W-1:0] soft_hp_i,
	input wire logic [svd_pkg::SOFT_W-1:0] soft_lp_i,
	input wire logic soft_valid_i,
	output logic soft_ready_o,
	output logic bit_o,
	output logic bit_valid_o,
	input wire logic [svd_pkg::ERR_W-1:0] ber_period_i,
	output logic [svd_pkg::ERR_W-1:0] ber_count_o,
	output logic ber_done_o
);
	svd_pkg::svd_state_type state_ff;
	svd_pkg::svd_rate_type rate_ff;
	svd_pkg::svd_rate_type cur_rate;
	logic prio_ff;
	logic cur_prio;
	logic [2:0] phase_ff;
	logic half_ff;
	logic at_bound;
	logic [svd_pkg::SOFT_W-1:0] x_hold_ff;
	logic [svd_pkg::SOFT_W-1:0] sel_soft;
	logic accept;
	logic need_x;
	logic need_y;
	logic step_vld;
	logic [svd_pkg::SOFT_W-1:0] step_x;
	logic [svd_pkg::SOFT_W-1:0] step_y;
	logic step_ex;
	logic step_ey;
	logic [svd_pkg::PM_W-1:0] pm_ff [svd_pkg::NUM_ST];
	logic [svd_pkg::PM_W-1:0] nxt_pm [svd_pkg::NUM_ST];
	logic [svd_pkg::NUM_ST-1:0] dec;
	logic [svd_pkg::NUM_ST-1:0] surv_mem [svd_pkg::MEM_DEPTH];
	logic [3:0] hard_mem [svd_pkg::MEM_DEPTH];
	logic [7:0] wptr_ff;
	logic [7:0] rd_ptr_ff;
	logic [7:0] emit_addr;
	logic [1:0] blocks_ff;
	logic [svd_pkg::CNT_W-1:0] cnt_ff;
	logic [5:0] tb_state_ff;
	logic [svd_pkg::BLK_LEN-1:0] out_buf_ff;
	logic bit_ff;
	logic bit_vld_ff;
	logic [3:0] hard_ff;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	// unknown rate codes fall back to the unpunctured rate
	function automatic svd_pkg::svd_rate_type fix_rate(input logic [2:0] r);
		fix_rate = (r > 3'h4) ? svd_pkg::RATE_1_2 : svd_pkg::svd_rate_type'(r);
	endfunction

	// branch cost of one soft bit against a hypothesis, erasures are neutral
	function automatic logic [5:0] bit_cost(input logic [4:0] s, input logic era,
		input logic hyp);
		bit_cost = era ? 6'h00 : {1'b0, hyp ? (svd_pkg::SOFT_MAX - s) : s};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// R8 switch at boundary
	// rate and stream only change between puncture periods so no step mixes streams
	assign at_bound = (phase_ff == 3'h0) && !half_ff;
	assign cur_rate = at_bound ? fix_rate(code_rate_i) : rate_ff;
	assign cur_prio = at_bound ? prio_sel_i : prio_ff;
	assign sel_soft = cur_prio ? soft_lp_i : soft_hp_i;
	assign soft_ready_o = (state_ff == svd_pkg::ST_FILL);
	assign accept = soft_valid_i && soft_ready_o;
	// R10 puncture pattern lookup
	assign need_x = svd_pkg::PUNCT_X[cur_rate][phase_ff];
	assign need_y = svd_pkg::PUNCT_Y[cur_rate][phase_ff];

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			rate_ff <= svd_pkg::RATE_1_2;
			prio_ff <= 1'b0;
		end
		else if (at_bound)
		begin
			rate_ff <= fix_rate(code_rate_i);
			prio_ff <= prio_sel_i;
		end
	end

	// R2 erasure insert
	// assemble one trellis step, refilling absent code bits as erasures
	always_comb
	begin
		step_vld = 1'b0;
		step_x = x_hold_ff;
		step_y = sel_soft;
		step_ex = 1'b0;
		step_ey = 1'b0;
		if (accept)
		begin
			if (need_x && !half_ff)
			begin
				if (!need_y)
				begin
					step_vld = 1'b1;
					step_x = sel_soft;
					step_ey = 1'b1;
				end
			end
			else
			begin
				step_vld = 1'b1;
				step_ex = !need_x;
			end
		end
	end

	// R1 full soft hold
	// first half of a pair is held until its partner arrives
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			half_ff <= 1'b0;
			phase_ff <= 3'h0;
			x_hold_ff <= '0;
		end
		else if (accept)
		begin
			if (need_x && !half_ff && need_y)
			begin
				x_hold_ff <= sel_soft;
				half_ff <= 1'b1;
			end
			else
			begin
				half_ff <= 1'b0;
				phase_ff <= (phase_ff == svd_pkg::PUNCT_PER[cur_rate] - 3'h1) ? 3'h0 : phase_ff + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// R3 add compare select
	// metrics wrap modulo, compared by signed difference, so no normalisation pass
	for (genvar ns = 0; ns < svd_pkg::NUM_ST; ns++)
	begin : g_acs
		logic [5:0] p0;
		logic [5:0] p1;
		logic [svd_pkg::PM_W-1:0] c0;
		logic [svd_pkg::PM_W-1:0] c1;
		logic [svd_pkg::PM_W-1:0] d;
		localparam logic [5:0] NS = 6'(ns);
		// predecessors share the newer five bits and differ in the one shifted out
		assign p0 = {NS[4:0], 1'b0};
		assign p1 = p0 | 6'h01;
		// R10 mother code branch
		assign c0 = pm_ff[p0] + svd_pkg::PM_W'(
			bit_cost(step_x, step_ex, ^({NS[5], p0} & svd_pkg::GEN_X))
			+ bit_cost(step_y, step_ey, ^({NS[5], p0} & svd_pkg::GEN_Y)));
		assign c1 = pm_ff[p1] + svd_pkg::PM_W'(
			bit_cost(step_x, step_ex, ^({NS[5], p1} & svd_pkg::GEN_X))
			+ bit_cost(step_y, step_ey, ^({NS[5], p1} & svd_pkg::GEN_Y)));
		assign d = c1 - c0;
		assign dec[ns] = d[svd_pkg::PM_W-1];
		assign nxt_pm[ns] = dec[ns] ? c1 : c0;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			pm_ff <= '{default: '0};
		else if (step_vld)
			pm_ff <= nxt_pm;
	end

	// one decision word and the hard decisions per step
	always_ff @(posedge clk_sys_i)
	begin
		if (step_vld)
		begin
			surv_mem[wptr_ff] <= dec;
			hard_mem[wptr_ff] <= {step_x[4], step_y[4], step_ex, step_ey};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// R4 block trace-back
	// input stalls during trace and emit; 256 cycles of work per 64 steps
	assign emit_addr = wptr_ff - svd_pkg::DEC_LAG + {1'b0, cnt_ff};

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			state_ff <= svd_pkg::ST_FILL;
			wptr_ff <= '0;
			rd_ptr_ff <= '0;
			blocks_ff <= '0;
			cnt_ff <= '0;
			tb_state_ff <= '0;
			out_buf_ff <= '0;
		end
		else
		begin
			unique case (state_ff)
				svd_pkg::ST_FILL:
				begin
					if (step_vld)
					begin
						wptr_ff <= wptr_ff + 8'h01;
						if (wptr_ff[5:0] == 6'h3F)
						begin
							if (blocks_ff == svd_pkg::WARM_BLKS)
							begin
								state_ff <= svd_pkg::ST_TRACE;
								rd_ptr_ff <= wptr_ff;
								tb_state_ff <= '0;
								cnt_ff <= '0;
							end
							else
								blocks_ff <= blocks_ff + 2'h1;
						end
					end
				end
				svd_pkg::ST_TRACE, svd_pkg::ST_DECODE:
				begin
					if (state_ff == svd_pkg::ST_DECODE)
						out_buf_ff[rd_ptr_ff[5:0]] <= tb_state_ff[5];
					tb_state_ff <= {tb_state_ff[4:0], surv_mem[rd_ptr_ff][tb_state_ff]};
					rd_ptr_ff <= rd_ptr_ff - 8'h01;
					cnt_ff <= cnt_ff + 1'b1;
					if (state_ff == svd_pkg::ST_TRACE && cnt_ff == svd_pkg::TB_LAST)
					begin
						state_ff <= svd_pkg::ST_DECODE;
						cnt_ff <= '0;
					end
					else if (state_ff == svd_pkg::ST_DECODE && cnt_ff == svd_pkg::BLK_LAST)
					begin
						state_ff <= svd_pkg::ST_EMIT;
						cnt_ff <= '0;
					end
				end
				svd_pkg::ST_EMIT:
				begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff == svd_pkg::BLK_LAST)
					begin
						state_ff <= svd_pkg::ST_FILL;
						cnt_ff <= '0;
					end
				end
				default:
					state_ff <= svd_pkg::ST_FILL;
			endcase
		end
	end

	// decoded bits leave oldest first, with their stored hard decisions
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			bit_ff <= 1'b0;
			bit_vld_ff <= 1'b0;
			hard_ff <= '0;
		end
		else
		begin
			bit_vld_ff <= (state_ff == svd_pkg::ST_EMIT);
			bit_ff <= out_buf_ff[cnt_ff[5:0]];
			hard_ff <= hard_mem[emit_addr];
		end
	end

	assign bit_o = bit_ff;
	assign bit_valid_o = bit_vld_ff;

	// R5 error monitor
	svd_ber_mon u_ber
	(
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.bit_i(bit_ff),
		.valid_i(bit_vld_ff),
		.hard_x_i(hard_ff[3]),
		.hard_y_i(hard_ff[2]),
		.era_x_i(hard_ff[1]),
		.era_y_i(hard_ff[0]),
		.period_i(ber_period_i),
		.count_o(ber_count_o),
		.done_o(ber_done_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	sequence s_trace_done;
		##128 state_ff == svd_pkg::ST_DECODE ##64 state_ff == svd_pkg::ST_EMIT;
	endsequence
	property p_traceback_len;
		$rose(state_ff == svd_pkg::ST_TRACE) |-> s_trace_done;
	endproperty
	a_traceback_len: assert property (p_traceback_len) else $error("trace-back length wrong"); // R4

	property p_word_per_step;
		step_vld |=> wptr_ff == $past(wptr_ff) + 8'h01;
	endproperty
	a_word_per_step: assert property (p_word_per_step) else $error("decision word not stored"); // R3

	property p_rate_half_plain;
		step_vld && cur_rate == svd_pkg::RATE_1_2 |-> !step_ex && !step_ey;
	endproperty
	a_rate_half_plain: assert property (p_rate_half_plain) else $error("erasure at rate 1/2"); // R2

	property p_pair_hold;
		accept && need_x && need_y && !half_ff |=> half_ff && x_hold_ff == $past(sel_soft);
	endproperty
	a_pair_hold: assert property (p_pair_hold) else $error("soft value not kept whole"); // R1

	property p_sel_boundary;
		!$stable(prio_ff) || !$stable(rate_ff) |-> $past(at_bound);
	endproperty
	a_sel_boundary: assert property (p_sel_boundary) else $error("selection changed mid period"); // R8

	property p_phase_range;
		phase_ff < svd_pkg::PUNCT_PER[rate_ff];
	endproperty
	a_phase_range: assert property (p_phase_range) else $error("puncture phase out of range"); // R10

	property p_emit_burst;
		$rose(bit_valid_o) |-> bit_valid_o [*8];
	endproperty
	a_emit_burst: assert property (p_emit_burst) else $error("output burst broken"); // R4
endmodule

//--- test/svd_src.sv
// upstream soft-decision source: mother code encoder, puncturing and sparse noise
`timescale 1ns/1ps
module svd_src
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [2:0] rate_i,
	input wire logic want_sel_i,
	input wire logic noise_i,
	input wire logic [15:0] steps_i,
	input wire logic ready_i,
	output logic [svd_pkg::SOFT_W-1:0] soft_hp_o,
	output logic [svd_pkg::SOFT_W-1:0] soft_lp_o,
	output logic soft_valid_o,
	output logic sel_o,
	output logic note_o,
	output logic note_bit_o,
	output logic [1:0] note_err_o
);
	integer seed = 32'h0000_6ECB;
	logic [5:0] st;
	logic [6:0] sh;
	logic took;
	logic b;
	logic [4:0] q[$];
	int p, r, gap;
	logic [15:0] made;
	logic nv;
	logic nn;
	int ne;
	////////////////////////////////////////////////////////////////////////////////
	// queue one code bit; isolated weak errors keep the trellis correctable
	task automatic push(input logic c);
		gap++;
		if (noise_i && gap > 40 && ($random(seed) & 15) == 0)
		begin
			q.push_back(c ? 5'h0C + 5'($random(seed) & 3) : 5'h10 + 5'($random(seed) & 3));
			ne++;
			gap = 0;
		end
		else
			q.push_back(c ? 5'h1F - 5'($random(seed) & 7) : 5'($random(seed) & 7));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// remember whether the offered value went in at this edge
	always @(posedge clk_sys_i)
		took <= soft_valid_o && ready_i;
	// offer held until taken; lines not carrying a request show noise
	always @(negedge clk_sys_i)
	begin
		nn = 1'b0;
		nv = soft_valid_o;
		if (rst_i)
		begin
			st = 6'h00;
			p = 0;
			made = 16'h0000;
			gap = 0;
			q.delete();
			nv = 1'b0;
			sel_o = want_sel_i;
		end
		else
		begin
			if (took)
			begin
				void'(q.pop_front());
				nv = 1'b0;
			end
			if (q.size() == 0 && made < steps_i)
			begin
				r = rate_i > 3'h4 ? 0 : int'(rate_i);
				if (p == 0)
					sel_o = want_sel_i;
				b = 1'($random(seed));
				sh = {b, st};
				st = sh[6:1];
				ne = 0;
				if (svd_pkg::PUNCT_X[r][p])
					push(^(sh & svd_pkg::GEN_X));
				if (svd_pkg::PUNCT_Y[r][p])
					push(^(sh & svd_pkg::GEN_Y));
				p = (p + 1) % int'(svd_pkg::PUNCT_PER[r]);
				made++;
				nn = 1'b1;
				note_bit_o = b;
				note_err_o = 2'(ne);
			end
			if (!nv && q.size() != 0)
				nv = ($random(seed) & 3) != 0;
		end
		// every line is written once per edge so the decoder never sees a glitch
		soft_valid_o = nv;
		note_o = nn;
		soft_hp_o = (nv && !sel_o) ? q[0] : 5'($random(seed));
		soft_lp_o = (nv && sel_o) ? q[0] : 5'($random(seed));
	end
endmodule

//--- test/tb_top.sv
// self-checking bench: coded runs over all rates, error monitor, stream select
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] code_rate_i = 3'h0;
	logic want_sel = 1'b0;
	logic noise = 1'b0;
	logic [15:0] steps = 16'h0000;
	logic [23:0] ber_period_i = 24'h00_0001;
	logic [4:0] soft_hp, soft_lp;
	logic soft_valid, soft_ready, prio_sel, bit_o, bit_valid, ber_done, note, note_bit;
	logic [1:0] note_err;
	logic [23:0] ber_count;
	logic pend;
	logic q_bit[$];
	int q_err[$];
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	int acc, acc_done, nb, low_run, hi_run, n_notes;
	int byte_bits, n_bytes;
	int per_tbl[6] = '{50, 37, 0, 64, 100, 1};
	////////////////////////////////////////////////////////////////////////////////
	svd_decoder u_dut
	(
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .code_rate_i(code_rate_i),
		.prio_sel_i(prio_sel), .soft_hp_i(soft_hp), .soft_lp_i(soft_lp),
		.soft_valid_i(soft_valid), .soft_ready_o(soft_ready), .bit_o(bit_o),
		.bit_valid_o(bit_valid), .ber_period_i(ber_period_i), .ber_count_o(ber_count),
		.ber_done_o(ber_done)
	);
	svd_src u_src
	(
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rate_i(code_rate_i), .want_sel_i(want_sel),
		.noise_i(noise), .steps_i(steps), .ready_i(soft_ready), .soft_hp_o(soft_hp),
		.soft_lp_o(soft_lp), .soft_valid_o(soft_valid), .sel_o(prio_sel), .note_o(note),
		.note_bit_o(note_bit), .note_err_o(note_err)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// clock and a hang limit well above six runs of about 2000 cycles
	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			error_cnt++;
			test_done();
		end
	end
	// the source notes each step's data bit and injected hard errors
	always @(posedge clk_sys_i)
		if (note)
		begin
			q_bit.push_back(note_bit);
			q_err.push_back(note_err);
			n_notes++;
		end
	// output watcher: oldest note against each decoded bit, plus run lengths
	always @(negedge clk_sys_i)
	begin
		if (rst_i)
		begin
			pend = 1'b0;
			acc = 0;
			nb = 0;
			low_run = 0;
			hi_run = 0;
			byte_bits = 0;
			n_bytes = 0;
		end
		else
		begin
			// count published one cycle after the interval
			if (pend)
				check(ber_count, 24'(acc_done));
			check(ber_done, pend);
			pend = 1'b0;
			if (bit_valid === 1'b1 && q_bit.size() == 0)
				check(bit_valid, 1'b0);
			else if (bit_valid === 1'b1)
			begin
				check(bit_o, q_bit.pop_front());
				acc += q_err.pop_front();
				hi_run++;
				nb++;
				// consumer packs bits into bytes for its depth-12 de-interleaver
				byte_bits = (byte_bits + 1) % 8;
				if (byte_bits == 0)
					n_bytes++;
				if (nb >= (ber_period_i == 0 ? 1 : int'(ber_period_i)))
				begin
					pend = 1'b1;
					acc_done = acc;
					acc = 0;
					nb = 0;
				end
			end
			else if (hi_run != 0)
			begin
				check(24'(hi_run), 24'h00_0040);
				// bursts end on a byte edge so framing stays undisturbed
				check(24'(byte_bits), 24'h00_0000);
				hi_run = 0;
			end
			// stall covers trace, decode and emit
			if (soft_ready === 1'b0)
				low_run++;
			else if (low_run != 0)
			begin
				check(24'(low_run), 24'h00_0100);
				low_run = 0;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// one reset per rate code; code 5 must act as 1/2; stream toggled mid-run
	initial
	begin
		for (int i = 0; i < 6; i++)
		begin
			@(negedge clk_sys_i);
			rst_i <= 1'b1;
			code_rate_i <= 3'(i);
			noise <= (i == 0 || i == 1 || i == 5);
			want_sel <= i[0];
			ber_period_i <= 24'(per_tbl[i]);
			steps <= 16'h0180;
			repeat (12) @(negedge clk_sys_i);
			q_bit.delete();
			q_err.delete();
			n_notes = 0;
			rst_i <= 1'b0;
			for (int k = 0; k < 6000; k++)
			begin
				@(negedge clk_sys_i);
				// switch to the other priority stream
				if (k == 700)
					want_sel <= ~want_sel;
				if (n_notes == 384 && q_bit.size() == 128 && soft_ready === 1'b1)
					break;
			end
			repeat (4) @(negedge clk_sys_i);
			check(24'(q_bit.size()), 24'h00_0080);
			// whole bytes reach the de-interleaver: four blocks of eight
			check(24'(n_bytes), 24'h00_0020);
		end
		test_done();
	end
endmodule
